// ==== design/fan_pkg.sv ====
// Purpose: shared constants and types for the two-phase fan commutation block
// Assumes: 100 MHz core clock; analog levels arrive as 10 mV codes
// Notes: long cycle counts are defaults for top-level parameters
package fan_pkg;

  // core clock
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;

  // threshold and setpoint levels, in millivolts
  localparam int UPPER_MV = 2000;
  localparam int LOWER_MV = 1000;
  localparam int SETPOINT_OPEN_MV = 1500;
  localparam int SETPOINT_LSB_MV = 10;
  localparam logic [9:0] UPPER_THRESHOLD = 10'(UPPER_MV / SETPOINT_LSB_MV);
  localparam logic [9:0] LOWER_THRESHOLD = 10'(LOWER_MV / SETPOINT_LSB_MV);
  localparam logic [9:0] SETPOINT_OPEN = 10'(SETPOINT_OPEN_MV / SETPOINT_LSB_MV);

  // pwm ramp: frequency and charge/discharge currents in nA
  localparam int PWM_FREQ_HZ = 24_000;
  localparam int PWM_CYCLES = CLK_HZ / PWM_FREQ_HZ;
  localparam int PWM_CHARGE_NA = 4_300;
  localparam int PWM_DISCHARGE_NA = 62_000;

  // stall timer: one tick per millisecond
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int RETRY_ON_MS = 330;
  localparam int RETRY_OFF_MS = 4000;
  // charging from zero to the upper level spans twice the between-threshold swing
  localparam int STALL_DETECT_MS = RETRY_ON_MS * UPPER_MV / (UPPER_MV - LOWER_MV);
  localparam int RETRY_ON_TICKS = RETRY_ON_MS / TICK_MS;
  localparam int RETRY_OFF_TICKS = RETRY_OFF_MS / TICK_MS;
  localparam int STALL_DETECT_TICKS = STALL_DETECT_MS / TICK_MS;

  // stall supervisor states, gray along detect -> on -> off
  typedef enum logic [1:0] {
    ST_DETECT = 2'h0,
    ST_RETRY_ON = 2'h1,
    ST_RETRY_OFF = 2'h3
  } stall_state_t;

  // variant of the stall/tach output pin
  typedef enum logic [1:0] {
    OUT_COMBINED = 2'h0,
    OUT_STALL_ONLY = 2'h1,
    OUT_TACH_ONLY = 2'h2
  } out_mode_t;

endpackage : fan_pkg

// ==== design/pwm_ramp.sv ====
// Purpose: digital model of the triangular pwm ramp and its setpoint compare
// Assumes: setpoint is a 10 mV code from logic on the same clock
// Notes: the ramp rises slowly and falls fast, as the capacitor does
`timescale 1ns/1ps
module pwm_ramp #(
  parameter int CYCLES = fan_pkg::PWM_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [9:0] setpoint,
  output logic window
);

  // rising share of the period follows the current ratio
  localparam int RISE = CYCLES * (fan_pkg::PWM_DISCHARGE_NA / 100)
    / ((fan_pkg::PWM_CHARGE_NA + fan_pkg::PWM_DISCHARGE_NA) / 100);
  localparam int FALL = CYCLES - RISE;
  localparam int SPAN = int'(fan_pkg::UPPER_THRESHOLD - fan_pkg::LOWER_THRESHOLD);

  logic [15:0] cnt; // position inside the pwm period
  logic [31:0] level_num; // setpoint above lower threshold
  logic [31:0] rise_lhs; // ramp progress while rising
  logic [31:0] fall_lhs; // ramp progress while falling
  logic rising; // first part of the period
  logic above; // ramp level exceeds setpoint
  logic next_window;

  // compare in the time domain to avoid a divider
  assign level_num = 32'(setpoint) - 32'(fan_pkg::LOWER_THRESHOLD);
  assign rising = 32'(cnt) < 32'(RISE);
  assign rise_lhs = 32'(cnt) * 32'(SPAN);
  assign fall_lhs = (32'(cnt) - 32'(RISE)) * 32'(SPAN);
  assign above = rising ? (rise_lhs > level_num * 32'(RISE))
                        : (fall_lhs < (32'(SPAN) - level_num) * 32'(FALL));
  // below the lower level the ramp is always above; at or over the upper, never
  assign next_window = (setpoint <= fan_pkg::LOWER_THRESHOLD) ? 1'b1 :
                       (setpoint >= fan_pkg::UPPER_THRESHOLD) ? 1'b0 : above;

  // period counter wraps once per pwm cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 16'h0000;
      window <= 1'b0;
    end else begin
      cnt <= (32'(cnt) == CYCLES - 1) ? 16'h0000 : cnt + 16'h0001;
      window <= next_window;
    end
  end

endmodule : pwm_ramp

// ==== design/fan_commutation.sv ====
// Purpose: commutation, pwm speed and stalled-rotor supervision of a two-phase fan
// Assumes: position sensor and external pwm arrive as logic levels from pins;
//   setpoint arrives as a 10 mV code from a converter on CLK
// Notes: one clock; stall timing runs on a 1 ms enable pulse
// Overview of operation
// - sensor plus above minus selects phase B
// - at most one phase active; opposite selects A
// - speed set by pwm on phase outputs
// - setpoint 2V gives zero, 1V full
// - open setpoint acts as 1.5V, half duty
// - setpoint at 2V or more disables drive, except with external pwm selected
// - combined output toggles at twice rotation
// - combined output held high while stalled
// - stall-only output high only when stalled
// - tach-only output is inverted sensor copy
// - stalled: short drive, long wait, repeat
// - detect charge from zero, retry between thresholds
// - retry on 0.33s, off 4.0s
// - ramp between thresholds sets 24kHz period
`timescale 1ns/1ps
module fan_commutation #(
  parameter int PWM_CYCLES = fan_pkg::PWM_CYCLES,
  parameter int TICK_CYCLES = fan_pkg::TICK_CYCLES,
  parameter int STALL_DETECT_TICKS = fan_pkg::STALL_DETECT_TICKS,
  parameter int RETRY_ON_TICKS = fan_pkg::RETRY_ON_TICKS,
  parameter int RETRY_OFF_TICKS = fan_pkg::RETRY_OFF_TICKS,
  parameter fan_pkg::out_mode_t OUT_MODE = fan_pkg::OUT_COMBINED
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HALL_POS,
  input wire logic HALL_NEG,
  input wire logic [9:0] SPEED_SETPOINT_IN,
  input wire logic SPEED_OPEN,
  input wire logic EXT_PWM_MODE,
  input wire logic PWM_RAMP_IN,
  output logic PHASE_A_DRIVE,
  output logic PHASE_B_DRIVE,
  output logic STALL_TACH_OUT,
  output logic STALL_TACH_OE_N,
  output logic STALLED
);

  // pin synchronisers: bit 0 hall+, 1 hall-, 2 open, 3 ext mode, 4 ext pwm
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pins; // raw pin levels
  logic [NSYNC-1:0] sync1; // first stage, read only by the second
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] filt; // accepted level once stages two and three agree
  logic [NSYNC-1:0] next_filt;

  assign pins = {PWM_RAMP_IN, EXT_PWM_MODE, SPEED_OPEN, HALL_NEG, HALL_POS};

  // a glitch shorter than one clock never reaches the filtered level
  assign next_filt = (sync3 & ~(sync2 ^ sync3)) |
                     (filt & (sync2 ^ sync3));

  // three flops then agreement filter
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
      filt <= 5'h00;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  wire hall_p = filt[0];
  wire hall_n = filt[1];
  wire sp_open = filt[2];
  wire ext_mode = filt[3];
  wire ext_pwm = filt[4]; // already a logic level: low means under 1V, high over 2V

  // commutation select
  logic phase_b_sel; // 1 while phase B is the active phase
  logic next_phase_b_sel;
  logic hall_edge; // commutation point seen

  // equal levels give no decision, so the last phase is kept
  assign next_phase_b_sel = (hall_p && !hall_n) ? 1'b1 :
                            (!hall_p && hall_n) ? 1'b0 : phase_b_sel;
  assign hall_edge = next_phase_b_sel != phase_b_sel;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase_b_sel <= 1'b0;
    end else begin
      phase_b_sel <= next_phase_b_sel;
    end
  end

  // speed setpoint: unconnected pin sits at the internal divider level
  logic [9:0] setpoint;
  logic disabled; // setpoint at or above the upper level
  logic ramp_window; // internal ramp above setpoint
  logic pwm_on;

  assign setpoint = sp_open ? fan_pkg::SETPOINT_OPEN : SPEED_SETPOINT_IN;
  assign disabled = setpoint >= fan_pkg::UPPER_THRESHOLD;

  // ramp between thresholds, compared against setpoint
  pwm_ramp #(
    .CYCLES(PWM_CYCLES)
  ) u_ramp (
    .clk(CLK),
    .arst_n(ARST_N),
    .setpoint(setpoint),
    .window(ramp_window)
  );

  // external source replaces the ramp when no capacitor is fitted
  assign pwm_on = ext_mode ? ext_pwm : (ramp_window && !disabled);

  // millisecond enable for the stall timer
  logic [16:0] tick_cnt;
  logic tick;

  assign tick = 32'(tick_cnt) == TICK_CYCLES - 1;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt <= 17'h0_0000;
    end else begin
      tick_cnt <= tick ? 17'h0_0000 : tick_cnt + 17'h0_0001;
    end
  end

  // stall supervisor: detect charge, then retry on/off cycling
  fan_pkg::stall_state_t state;
  fan_pkg::stall_state_t next_state;
  logic [12:0] stall_timer_ramp; // elapsed ticks in the current phase
  logic [12:0] next_timer;
  logic stalled;
  logic next_stalled;
  logic timer_at_end; // current phase has reached its threshold
  logic [31:0] phase_len;

  // each phase is one charge or discharge between two levels
  assign phase_len = (state == fan_pkg::ST_DETECT) ? 32'(STALL_DETECT_TICKS) :
                     (state == fan_pkg::ST_RETRY_ON) ? 32'(RETRY_ON_TICKS) :
                     32'(RETRY_OFF_TICKS);
  assign timer_at_end = tick && (32'(stall_timer_ramp) + 32'd1 >= phase_len);

  always_comb begin
    next_state = state;
    next_timer = stall_timer_ramp;
    next_stalled = stalled;
    if (hall_edge) begin
      // rotation seen: timer back to zero and flag dropped
      next_state = fan_pkg::ST_DETECT;
      next_timer = 13'h0000;
      next_stalled = 1'b0;
    end else if (tick) begin
      next_timer = stall_timer_ramp + 13'h0001;
      unique case (state)
        fan_pkg::ST_DETECT: begin
          // no edge within the detect time: declare stall, start a retry burst
          if (timer_at_end) begin
            next_state = fan_pkg::ST_RETRY_ON;
            next_timer = 13'h0000;
            next_stalled = 1'b1;
          end
        end
        fan_pkg::ST_RETRY_ON: begin
          if (timer_at_end) begin
            next_state = fan_pkg::ST_RETRY_OFF;
            next_timer = 13'h0000;
          end
        end
        fan_pkg::ST_RETRY_OFF: begin
          if (timer_at_end) begin
            next_state = fan_pkg::ST_RETRY_ON;
            next_timer = 13'h0000;
          end
        end
        default: begin
          // unused code recovers to a fresh detect
          next_state = fan_pkg::ST_DETECT;
          next_timer = 13'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= fan_pkg::ST_DETECT;
      stall_timer_ramp <= 13'h0000;
      stalled <= 1'b0;
    end else begin
      state <= next_state;
      stall_timer_ramp <= next_timer;
      stalled <= next_stalled;
    end
  end

  // phase outputs: only the selected phase may carry the pwm
  logic drive_allowed; // not in the retry wait
  logic next_a;
  logic next_b;

  assign drive_allowed = state != fan_pkg::ST_RETRY_OFF;
  assign next_b = phase_b_sel && pwm_on && drive_allowed;
  assign next_a = !phase_b_sel && pwm_on && drive_allowed;

  // stall/tach pin level for the chosen variant
  logic next_pin;
  assign next_pin = (OUT_MODE == fan_pkg::OUT_STALL_ONLY) ? stalled :
                    (OUT_MODE == fan_pkg::OUT_TACH_ONLY) ? !phase_b_sel :
                    (stalled || !phase_b_sel);

  // registered outputs keep the drive free of decode glitches
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PHASE_A_DRIVE <= 1'b0;
      PHASE_B_DRIVE <= 1'b0;
      STALL_TACH_OE_N <= 1'b1;
    end else begin
      PHASE_A_DRIVE <= next_a;
      PHASE_B_DRIVE <= next_b;
      // open collector: enable low pulls the pin down, release lets it rise
      STALL_TACH_OE_N <= next_pin;
    end
  end

  // only ever drives low; the high level comes from the external pull-up
  assign STALL_TACH_OUT = 1'b0;
  assign STALLED = stalled;

endmodule : fan_commutation

// ==== bench/fan_commutation_properties.sv ====
// Purpose: port-level properties of the fan commutation block
// Assumes: tick and retry counts arrive from the bound instance
// Notes: stall windows carry margin for input sync and tick phase
`timescale 1ns/1ps
module fan_props #(
  parameter int TICK_CYCLES = 10,
  parameter int STALL_DETECT_TICKS = 6,
  parameter int RETRY_ON_TICKS = 3,
  parameter int RETRY_OFF_TICKS = 12,
  parameter fan_pkg::out_mode_t OUT_MODE = fan_pkg::OUT_COMBINED
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HALL_POS,
  input wire logic HALL_NEG,
  input wire logic [9:0] SPEED_SETPOINT_IN,
  input wire logic SPEED_OPEN,
  input wire logic EXT_PWM_MODE,
  input wire logic PWM_RAMP_IN,
  input wire logic PHASE_A_DRIVE,
  input wire logic PHASE_B_DRIVE,
  input wire logic STALL_TACH_OUT,
  input wire logic STALL_TACH_OE_N,
  input wire logic STALLED
);
  localparam int T = TICK_CYCLES;
  localparam int DET = STALL_DETECT_TICKS;
  localparam int ON = RETRY_ON_TICKS;
  localparam int OFF = RETRY_OFF_TICKS;
  logic [31:0] quiet; // cycles since either sensor pin last moved
  logic full; // setpoint pin asks for full drive
  assign full = SPEED_SETPOINT_IN <= 10'h064 && !SPEED_OPEN && !EXT_PWM_MODE;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // quiet time counter, saturating so a long stall never wraps
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) quiet <= 32'h0000_0000;
    else if ($changed(HALL_POS) || $changed(HALL_NEG)) quiet <= 32'h0000_0000;
    else if (quiet != 32'hFFFF_FFFF) quiet <= quiet + 32'h0000_0001;
  end
  one_phase_a: assert property (!(PHASE_A_DRIVE && PHASE_B_DRIVE))
    else $error("both phases driven");
  sel_a_a: assert property ((full && !STALLED && !HALL_POS && HALL_NEG)[*8] |-> PHASE_A_DRIVE && !PHASE_B_DRIVE)
    else $error("phase a not selected");
  sel_b_a: assert property ((full && !STALLED && HALL_POS && !HALL_NEG)[*8] |-> PHASE_B_DRIVE)
    else $error("phase b not driven");
  drive_off_a: assert property ((SPEED_SETPOINT_IN >= 10'h0C8 && !SPEED_OPEN && !EXT_PWM_MODE)[*8]
    |-> !PHASE_A_DRIVE && !PHASE_B_DRIVE) else $error("drive not disabled");
  tach_low_a: assert property ((!STALLED && HALL_POS && !HALL_NEG)[*8] |-> !STALL_TACH_OE_N)
    else $error("pin not low on sensor high");
  tach_only_a: assert property ((OUT_MODE == fan_pkg::OUT_TACH_ONLY && !HALL_POS && HALL_NEG)[*8]
    |-> STALL_TACH_OE_N) else $error("tach pin not released");
  // the pin is released during reset and follows the flag only one edge after release
  stall_only_a: assert property (OUT_MODE == fan_pkg::OUT_STALL_ONLY && $past(ARST_N)
    && STALLED == $past(STALLED) |-> STALL_TACH_OE_N == STALLED) else $error("stall pin wrong");
  stall_hold_a: assert property (OUT_MODE == fan_pkg::OUT_COMBINED && STALLED && $past(STALLED)
    |-> STALL_TACH_OE_N) else $error("pin not high while stalled");
  stall_early_a: assert property (quiet > 8 && quiet < (DET - 1) * T |-> !STALLED)
    else $error("stall too early");
  stall_late_a: assert property (quiet > (DET + 1) * T + 8 |-> STALLED)
    else $error("stall missing");
  retry_on_a: assert property (full && quiet > (DET + 1) * T + 8 && quiet < (DET + ON - 1) * T
    |-> PHASE_A_DRIVE || PHASE_B_DRIVE) else $error("no retry drive");
  retry_off_a: assert property (quiet > (DET + ON + 1) * T + 8 && quiet < (DET + ON + OFF - 1) * T
    |-> !PHASE_A_DRIVE && !PHASE_B_DRIVE) else $error("drive in retry wait");
  edge_clear_a: assert property ($changed(HALL_POS) && HALL_POS != HALL_NEG |-> ##[1:8] !STALLED)
    else $error("stall not cleared");
  // external source: drive follows the synced pwm level, the setpoint is ignored
  ext_on_a: assert property ((EXT_PWM_MODE && PWM_RAMP_IN && !STALLED)[*8] |-> PHASE_A_DRIVE || PHASE_B_DRIVE)
    else $error("no drive on external high");
  ext_off_a: assert property ((EXT_PWM_MODE && !PWM_RAMP_IN)[*8] |-> !PHASE_A_DRIVE && !PHASE_B_DRIVE)
    else $error("drive on external low");
  // open drain data never drives high; the pull-up gives the high level
  drain_low_a: assert property (!STALL_TACH_OUT)
    else $error("open drain data not low");
  cover property ($rose(STALLED));
  cover property ($rose(PHASE_B_DRIVE));
  cover property (EXT_PWM_MODE && $rose(PHASE_A_DRIVE));
endmodule : fan_props

bind fan_commutation fan_props #(.TICK_CYCLES(TICK_CYCLES), .STALL_DETECT_TICKS(STALL_DETECT_TICKS),
  .RETRY_ON_TICKS(RETRY_ON_TICKS), .RETRY_OFF_TICKS(RETRY_OFF_TICKS), .OUT_MODE(OUT_MODE)) i_props (
  .CLK(CLK), .ARST_N(ARST_N), .HALL_POS(HALL_POS), .HALL_NEG(HALL_NEG), .SPEED_SETPOINT_IN(SPEED_SETPOINT_IN),
  .SPEED_OPEN(SPEED_OPEN), .EXT_PWM_MODE(EXT_PWM_MODE), .PWM_RAMP_IN(PWM_RAMP_IN), .PHASE_A_DRIVE(PHASE_A_DRIVE),
  .PHASE_B_DRIVE(PHASE_B_DRIVE), .STALL_TACH_OUT(STALL_TACH_OUT), .STALL_TACH_OE_N(STALL_TACH_OE_N),
  .STALLED(STALLED));

// ==== bench/hall_sensor_model.sv ====
// Purpose: rotor position sensor, spinning or resting at a chosen pole
// Assumes: one sensor change every HALF clocks while spinning
// Notes: outputs are always complementary, as a switching sensor gives
`timescale 1ns/1ps
module hall_sensor_model #(
  parameter int HALF = 20
) (
  input wire logic clk,
  input wire logic spin,
  input wire logic rest_b,
  output logic hall_pos,
  output logic hall_neg
);
  int cnt; // clocks since the last pole change
  initial begin
    hall_pos = 1'b0;
    hall_neg = 1'b1;
    cnt = 0;
  end
  // a stopped rotor holds one pole, so levels stay put rather than float
  always @(posedge clk) begin
    cnt <= (spin && cnt < HALF - 1) ? cnt + 1 : 0;
    if (!spin || cnt == HALF - 1) begin
      hall_pos <= spin ? !hall_pos : rest_b;
      hall_neg <= spin ? hall_pos : !rest_b;
    end
  end
endmodule : hall_sensor_model

// ==== bench/test_two_phase_fan_commutation_stall.sv ====
// Purpose: self-checking bench for the fan block, all three pin variants side by side
// Assumes: shortened pwm and tick counts
// Notes: index 0 combined, 1 stall-only, 2 tach-only
`timescale 1ns/1ps
module test_two_phase_fan_commutation_stall;
  localparam int PWM_N = 100; // shortened pwm period
  logic clk, arst_n, spin, rest_b, speed_open, ext_mode, ramp_in, hall_pos, hall_neg;
  logic [9:0] setpoint;
  logic [2:0] a_drv, b_drv, oe_n, stalled; // one bit per variant
  int n_mismatch, n_tests, cycles, n;
  hall_sensor_model #(.HALF(20)) i_hall (.clk(clk), .spin(spin), .rest_b(rest_b), .hall_pos(hall_pos),
    .hall_neg(hall_neg));
  for (genvar m = 0; m < 3; m++) begin : g_var
    fan_commutation #(.PWM_CYCLES(PWM_N), .TICK_CYCLES(10), .STALL_DETECT_TICKS(6), .RETRY_ON_TICKS(3),
      .RETRY_OFF_TICKS(12), .OUT_MODE(fan_pkg::out_mode_t'(m))) i_dut (.CLK(clk), .ARST_N(arst_n),
      .HALL_POS(hall_pos), .HALL_NEG(hall_neg), .SPEED_SETPOINT_IN(setpoint), .SPEED_OPEN(speed_open),
      .EXT_PWM_MODE(ext_mode), .PWM_RAMP_IN(ramp_in), .PHASE_A_DRIVE(a_drv[m]), .PHASE_B_DRIVE(b_drv[m]),
      .STALL_TACH_OUT(), .STALL_TACH_OE_N(oe_n[m]), .STALLED(stalled[m]));
  end
  always #5 clk = ~clk;
  // hang guard, far above the roughly 1700 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task rest_at(input logic b);
    @(posedge clk);
    spin <= 1'b0;
    rest_b <= b;
    cyc(12);
  endtask : rest_at
  task t_commute;
    @(posedge clk);
    setpoint <= 10'h064;
    rest_at(1'b1);
    check({a_drv[0], b_drv[0], oe_n}, {2'b01, 3'b000}, "sensor high");
    rest_at(1'b0);
    check({a_drv[0], b_drv[0], oe_n}, {2'b10, 3'b101}, "sensor low");
  endtask : t_commute
  task t_duty;
    int want [5] = '{100, 50, 25, 0, 50};
    int tol [5] = '{0, 6, 6, 0, 6};
    logic [9:0] code [5] = '{10'h064, 10'h096, 10'h0AF, 10'h0C8, 10'h0C8};
    @(posedge clk);
    spin <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      setpoint <= code[i];
      speed_open <= (i == 4);
      cyc(PWM_N);
      n = 0;
      repeat (PWM_N) begin
        @(posedge clk);
        #1;
        n = n + int'(a_drv[0] | b_drv[0]);
      end
      check(n >= want[i] - tol[i] && n <= want[i] + tol[i], 1'b1, "duty");
    end
  endtask : t_duty
  task t_tach;
    logic prev;
    int falls;
    @(posedge clk);
    speed_open <= 1'b0;
    setpoint <= 10'h064;
    #1;
    prev = oe_n[0];
    falls = 0;
    repeat (400) begin
      @(posedge clk);
      #1;
      falls = falls + int'(prev === 1'b1 && oe_n[0] === 1'b0);
      prev = oe_n[0];
    end
    check(falls >= 9 && falls <= 11, 1'b1, "tach count");
    check(stalled, 3'b000, "stall while spinning");
  endtask : t_tach
  task t_ext;
    @(posedge clk);
    ext_mode <= 1'b1;
    speed_open <= 1'b1;
    setpoint <= 10'h0C8;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ramp_in <= !i[0];
      cyc(12);
      check(a_drv[0] | b_drv[0], !i[0], "external pwm");
    end
  endtask : t_ext
  task t_stall;
    @(posedge clk);
    ext_mode <= 1'b0;
    speed_open <= 1'b0;
    setpoint <= 10'h064;
    rest_at(!hall_pos);
    cyc(33);
    check(stalled, 3'b000, "stall early");
    cyc(45);
    check(stalled, 3'b111, "stall missing");
    check({oe_n[1:0], oe_n[2]}, {2'b11, !hall_pos}, "pin in stall");
    cyc(60);
    check({a_drv, b_drv}, 6'h00, "drive in retry wait");
    @(posedge clk);
    spin <= 1'b1;
    cyc(30);
    check(stalled, 3'b000, "stall kept");
  endtask : t_stall
  task print_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {spin, rest_b, speed_open, ext_mode, ramp_in} = 5'h00;
    setpoint = 10'h064;
    {n_mismatch, n_tests, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    cyc(2);
    t_commute();
    t_duty();
    t_tach();
    t_ext();
    t_stall();
    print_verdict();
  end
endmodule : test_two_phase_fan_commutation_stall
